// file: hw/aqms_pkg.sv
// Shared constants of the queue mode and status block: register map,
// status field layout, mode encodings and reset values.
// Assumes a 16-bit register port with byte addresses on word boundaries.
package aqms_pkg;

   // -------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   localparam logic [3:0] OFS_QUEUE_TWO_CTRL = 4'h0;  // Mode field and single-scan enable
   localparam logic [3:0] OFS_QUEUE_STATUS_0 = 4'h4;  // Main status register
   localparam logic [3:0] OFS_IRQ_STATUS     = 4'h8;  // Sticky event bits, write one to clear
   localparam logic [3:0] OFS_IRQ_MASK       = 4'hc;  // Event enables

   // -------------------------------------------------------------
   // Queue-two control layout
   // -------------------------------------------------------------
   localparam int unsigned SSE_BIT  = 13;
   localparam int unsigned MODE_LSB = 8;
   localparam int unsigned MODE_W   = 5;

   // -------------------------------------------------------------
   // Status layout: six flags above the state code and pointer
   // -------------------------------------------------------------
   localparam int unsigned FLAG_N   = 6;
   localparam int unsigned FLAG_LSB = 10;
   localparam int unsigned QS_LSB   = 6;
   localparam int unsigned QS_W     = 4;
   localparam int unsigned CWP_W    = 6;

   // Flag index inside the six-bit flag group
   localparam int unsigned F_CF1  = 5;
   localparam int unsigned F_PF1  = 4;
   localparam int unsigned F_CF2  = 3;
   localparam int unsigned F_PF2  = 2;
   localparam int unsigned F_QUEUE_ONE_TRIGGER_OVERRUN = 1;
   localparam int unsigned F_QUEUE_TWO_TRIGGER_OVERRUN = 0;

   // -------------------------------------------------------------
   // Mode encodings (low four bits; bit 4 selects continuous scan)
   // -------------------------------------------------------------
   localparam logic [3:0] MODE_LO_DISABLED = 4'h0;
   localparam logic [3:0] MODE_LO_SW       = 4'h1;
   localparam logic [3:0] MODE_LO_EXT_RISE = 4'h2;
   localparam logic [3:0] MODE_LO_EXT_FALL = 4'h3;
   localparam logic [3:0] MODE_LO_TMR_FIRST = 4'h4;
   localparam logic [3:0] MODE_LO_TMR_LAST  = 4'he;
   localparam logic [4:0] TMR_EXP_OFFSET   = 5'h3;  // Code 4 gives two to the seventh

   // -------------------------------------------------------------
   // Timer and reset values
   // -------------------------------------------------------------
   localparam int unsigned TMR_W        = 17;
   localparam int unsigned CONVERTER_CLOCK_DIV_DEF = 4;       // Reference clocks per converter clock
   localparam logic [DATA_W-1:0] RST_CTRL = 16'h0000;
   localparam logic [DATA_W-1:0] RST_STATUS = 16'h0000;
   localparam logic [FLAG_N-1:0] RST_MASK = 6'h00;

   typedef enum logic [2:0] {
      Q2_IDLE,
      Q2_PEND,
      Q2_ACTIVE,
      Q2_PAUSED,
      Q2_SUSP
   } aqms_q2_state_e;

endpackage

// file: hw/aqms_timer.sv
// Converter clock divider and interval/periodic timer for queue two.
// Assumes one reference clock; the converter clock is an enable pulse.
`timescale 1ns/1ps
module aqms_timer #(
   parameter int unsigned CONVERTER_CLOCK_DIV = aqms_pkg::CONVERTER_CLOCK_DIV_DEF
) (
   input  wire logic  ref_clk_in,
   input  wire logic  reset_in,
   aqms_timer_if.timer tmr
);
   import aqms_pkg::*;

   logic [15:0]      div_q;
   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] mask_w;
   logic             div_wrap_w;

   // -------------------------------------------------------------
   // Converter clock enable
   // -------------------------------------------------------------
   assign div_wrap_w  = (div_q == 16'(CONVERTER_CLOCK_DIV - 1));
   assign tmr.converter_clock_en = div_wrap_w;

   // Free-running divider so the converter clock never stops
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_wrap_w ? 16'h0000 : div_q + 16'h0001;
      end
   end

   // -------------------------------------------------------------
   // Interval counter
   // -------------------------------------------------------------
   // Low bits all ones marks the end of each power-of-two interval
   assign mask_w     = TMR_W'((18'h00001 << tmr.exponent) - 18'h00001);
   assign tmr.expire = tmr.run & div_wrap_w & ((cnt_q & mask_w) == mask_w);

   // Cleared while idle so the first interval is a full one
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_q <= '0;
      end else if (!tmr.run) begin
         cnt_q <= '0;
      end else if (div_wrap_w) begin
         cnt_q <= cnt_q + TMR_W'(1);
      end
   end

endmodule

// file: hw/aqms_timer_if.sv
// Link between the queue controller and its interval/periodic timer.
// Assumes both ends run on the reference clock.
`timescale 1ns/1ps
interface aqms_timer_if;
   logic       run;       // Timer counts while high, clears while low
   logic [4:0] exponent;  // Interval is two to this power in converter clocks
   logic       converter_clock_en;   // One-cycle converter clock enable
   logic       expire;    // One-cycle pulse at each interval end

   modport ctrl  (output run, output exponent, input converter_clock_en, input expire);
   modport timer (input run, input exponent, output converter_clock_en, output expire);
endinterface

// file: hw/aqms_top.sv
// Queue-two mode control and main status register of a queued converter.
// Assumes the conversion engine reports each stored result as a pulse and
// that queue-one state and triggers come from the queue-one sequencer.
//
// What this block does
// - Mode 00000 disables queue two entirely
// - Mode 00001 scans once on enable write
// - Modes 00010/00011 scan once on rise/fall
// - Modes 00100-01110 interval single scan, 2^7..2^17
// - Mode 10001 continuous scan started by enable
// - Modes 10010/10011 continuous scan per edge
// - Modes 10100-11110 periodic continuous scan, 2^7..2^17
// - Flags clear by zero write after read-one
// - Other status fields are read-only
// - Completion flag set after last result stored
// - Pause flag set after pause word stored
// - Queue-one overrun only while queue one active
// - Queue-one overrun only in external trigger modes
// - Queue-two overrun while active, suspended or pending
// - Queue-two overrun never in software modes
// - Joint state code reports both queues
// - Single-scan enable always reads zero
// - Single-scan enable self-clears after scan completes, except in continuous modes
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module aqms_top #(
   parameter int unsigned CONVERTER_CLOCK_DIV = aqms_pkg::CONVERTER_CLOCK_DIV_DEF
) (
   input  wire logic                        ref_clk_in,
   input  wire logic                        reset_in,
   input  wire logic [aqms_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [aqms_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   output logic      [aqms_pkg::DATA_W-1:0] reg_rdata_out,
   input  wire logic                        external_trigger_two_in,
   input  wire logic                        q1_active_in,
   input  wire logic                        q1_paused_in,
   input  wire logic                        q1_ext_mode_in,
   input  wire logic                        q1_trigger_in,
   input  wire logic                        conv_done_in,
   input  wire logic                        conv_queue_two_in,
   input  wire logic                        conv_last_in,
   input  wire logic                        conv_pause_in,
   input  wire logic [aqms_pkg::CWP_W-1:0]  command_word_pointer_in,
   output logic                             q2_run_out,
   output logic                             q2_trigger_pending_out,
   output logic                             irq_out
);
   import aqms_pkg::*;

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   aqms_timer_if tmr_if ();

   logic [MODE_W-1:0] mode_q;
   logic              sse_q;
   logic              sse_start_q;
   logic              ext_prev_q;
   aqms_q2_state_e    state_q;
   aqms_q2_state_e    state_d;
   logic [FLAG_N-1:0] flags_q;
   logic [FLAG_N-1:0] flags_d;
   logic [FLAG_N-1:0] armed_q;
   logic [FLAG_N-1:0] armed_d;
   logic [FLAG_N-1:0] flag_set_w;
   logic [FLAG_N-1:0] irq_stat_q;
   logic [FLAG_N-1:0] irq_mask_q;
   logic [CWP_W-1:0]  cwp_q;
   logic [DATA_W-1:0] rdata_q;

   logic              sel_ctrl_w;
   logic              sel_stat_w;
   logic              sel_istat_w;
   logic              sel_imask_w;
   logic              ctrl_wr_w;
   logic              stat_wr_w;
   logic              stat_rd_w;
   logic [MODE_W-1:0] wr_mode_w;
   logic              mode_chg_w;

   logic [3:0]        mode_lo_w;
   logic              mode_cont_w;
   logic              mode_sw_w;
   logic              mode_ext_w;
   logic              mode_tmr_w;
   logic              mode_valid_w;
   logic              ext_rise_w;
   logic              ext_fall_w;
   logic              ext_edge_w;
   logic              trig2_w;
   logic              armed2_w;
   logic              busy2_w;
   logic              q2_done_w;
   logic              q2_last_w;
   logic              q2_pause_w;
   logic [1:0]        qs_hi_w;
   logic [1:0]        qs_lo_w;
   logic [QS_W-1:0]   qs_w;
   logic [DATA_W-1:0] status_w;
   logic [DATA_W-1:0] ctrl_rd_w;
   logic [DATA_W-1:0] rd_mux_w;

   // -------------------------------------------------------------
   // Register decode
   // -------------------------------------------------------------
   assign sel_ctrl_w  = (reg_addr_in == OFS_QUEUE_TWO_CTRL);
   assign sel_stat_w  = (reg_addr_in == OFS_QUEUE_STATUS_0);
   assign sel_istat_w = (reg_addr_in == OFS_IRQ_STATUS);
   assign sel_imask_w = (reg_addr_in == OFS_IRQ_MASK);
   assign ctrl_wr_w   = reg_wr_in & sel_ctrl_w;
   assign stat_wr_w   = reg_wr_in & sel_stat_w;
   assign stat_rd_w   = reg_rd_in & sel_stat_w;
   assign wr_mode_w   = reg_wdata_in[MODE_LSB +: MODE_W];
   assign mode_chg_w  = ctrl_wr_w & (wr_mode_w != mode_q);

   // -------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------
   // Low four bits pick the trigger source, bit 4 picks continuous scan
   assign mode_lo_w    = mode_q[3:0];
   assign mode_cont_w  = mode_q[MODE_W-1];
   assign mode_sw_w    = (mode_lo_w == MODE_LO_SW);
   assign mode_ext_w   = (mode_lo_w == MODE_LO_EXT_RISE) |
                         (mode_lo_w == MODE_LO_EXT_FALL);
   assign mode_tmr_w   = (mode_lo_w >= MODE_LO_TMR_FIRST) &
                         (mode_lo_w <= MODE_LO_TMR_LAST);
   // Disabled and reserved codes start nothing
   assign mode_valid_w = (mode_lo_w != MODE_LO_DISABLED) &
                         (mode_sw_w | mode_ext_w | mode_tmr_w);

   // -------------------------------------------------------------
   // Trigger sources
   // -------------------------------------------------------------
   // Trigger pin is synchronous; one flop of history finds its edges
   assign ext_rise_w = external_trigger_two_in & ~ext_prev_q;
   assign ext_fall_w = ~external_trigger_two_in & ext_prev_q;
   assign ext_edge_w = (mode_lo_w == MODE_LO_EXT_FALL) ? ext_fall_w : ext_rise_w;

   // Timer runs only in timer modes once the queue is armed
   assign tmr_if.run      = mode_tmr_w & armed2_w;
   assign tmr_if.exponent = 5'(mode_lo_w) + TMR_EXP_OFFSET;

   // One trigger line regardless of source
   assign trig2_w = mode_valid_w &
                    ((mode_sw_w  & sse_start_q) |
                     (mode_ext_w & ext_edge_w)  |
                     (mode_tmr_w & tmr_if.expire));

   // Single scans and the software continuous scan wait for the enable
   assign armed2_w = mode_valid_w &
                     ((mode_cont_w & ~mode_sw_w) | sse_q | sse_start_q);

   // -------------------------------------------------------------
   // Converter reports
   // -------------------------------------------------------------
   assign q2_done_w  = conv_done_in & conv_queue_two_in;
   assign q2_last_w  = q2_done_w & conv_last_in;
   assign q2_pause_w = q2_done_w & conv_pause_in;
   assign busy2_w    = (state_q == Q2_ACTIVE) | (state_q == Q2_SUSP) | (state_q == Q2_PEND);

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   // Enable is taken a cycle late so it acts under the mode written with it
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mode_q      <= RST_CTRL[MODE_LSB +: MODE_W];
         sse_start_q <= 1'b0;
      end else begin
         sse_start_q <= ctrl_wr_w & reg_wdata_in[SSE_BIT];
         if (ctrl_wr_w) begin
            mode_q <= wr_mode_w;
         end
      end
   end

   // Enable self-clears when its single scan completes or the mode moves
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sse_q <= 1'b0;
      end else if (sse_start_q) begin
         sse_q <= 1'b1;
      end else if (mode_chg_w | (q2_last_w & ~mode_cont_w)) begin
         sse_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Queue-two sequencing
   // -------------------------------------------------------------
   // Queue one always has priority; queue two waits or suspends for it
   always_comb begin
      state_d = state_q;
      case (state_q)
         Q2_IDLE: begin
            if (trig2_w & armed2_w) begin
               state_d = q1_active_in ? Q2_PEND : Q2_ACTIVE;
            end
         end
         Q2_PEND: begin
            if (!q1_active_in) begin
               state_d = Q2_ACTIVE;
            end
         end
         Q2_ACTIVE: begin
            if (q2_last_w) begin
               // Software continuous scan restarts at once, others wait
               state_d = (mode_cont_w & mode_sw_w) ? Q2_ACTIVE : Q2_IDLE;
            end else if (q2_pause_w) begin
               state_d = Q2_PAUSED;
            end else if (q1_active_in) begin
               state_d = Q2_SUSP;
            end
         end
         Q2_PAUSED: begin
            if (trig2_w) begin
               state_d = q1_active_in ? Q2_PEND : Q2_ACTIVE;
            end
         end
         Q2_SUSP: begin
            if (!q1_active_in) begin
               state_d = Q2_ACTIVE;
            end
         end
         default: begin
            state_d = Q2_IDLE;
         end
      endcase
      if (!mode_valid_w | mode_chg_w) begin
         state_d = Q2_IDLE;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= Q2_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign q2_run_out             = (state_q == Q2_ACTIVE);
   assign q2_trigger_pending_out = (state_q == Q2_PEND);

   // -------------------------------------------------------------
   // Status flag events
   // -------------------------------------------------------------
   assign flag_set_w[F_CF1]  = conv_done_in & ~conv_queue_two_in & conv_last_in;
   assign flag_set_w[F_PF1]  = conv_done_in & ~conv_queue_two_in & conv_pause_in;
   assign flag_set_w[F_CF2]  = q2_last_w;
   assign flag_set_w[F_PF2]  = q2_pause_w;
   assign flag_set_w[F_QUEUE_ONE_TRIGGER_OVERRUN] = q1_trigger_in & q1_active_in & q1_ext_mode_in;
   // Software triggers never count as overruns
   assign flag_set_w[F_QUEUE_TWO_TRIGGER_OVERRUN] = trig2_w & ~mode_sw_w & busy2_w;

   // -------------------------------------------------------------
   // Clear-after-read flags
   // -------------------------------------------------------------
   // A flag clears only on a zero write after it was read as one; a new
   // event in the same cycle wins and demands a fresh read
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
         always_comb begin
            flags_d[gi] = flags_q[gi];
            armed_d[gi] = armed_q[gi];
            if (stat_rd_w) begin
               armed_d[gi] = flags_q[gi];
            end
            if (stat_wr_w) begin
               if (armed_q[gi] & ~reg_wdata_in[FLAG_LSB + gi]) begin
                  flags_d[gi] = 1'b0;
               end
               armed_d[gi] = 1'b0;
            end
            if (flag_set_w[gi]) begin
               flags_d[gi] = 1'b1;
               armed_d[gi] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         flags_q <= RST_STATUS[FLAG_LSB +: FLAG_N];
         armed_q <= '0;
      end else begin
         flags_q <= flags_d;
         armed_q <= armed_d;
      end
   end

   // Pointer follows the engine; software cannot write it
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cwp_q <= RST_STATUS[CWP_W-1:0];
      end else begin
         cwp_q <= command_word_pointer_in;
      end
   end

   // -------------------------------------------------------------
   // Joint queue state
   // -------------------------------------------------------------
   assign qs_hi_w = q1_active_in ? 2'h2 : (q1_paused_in ? 2'h1 : 2'h0);
   assign qs_lo_w = (state_q == Q2_PAUSED) ? 2'h1 :
                    (state_q == Q2_PEND)   ? 2'h3 :
                    ((state_q == Q2_ACTIVE) | (state_q == Q2_SUSP)) ? 2'h2 : 2'h0;
   assign qs_w    = {qs_hi_w, qs_lo_w};

   // Only the flag group is writable; the rest is assembled from state
   assign status_w = {flags_q, qs_w, cwp_q};

   // -------------------------------------------------------------
   // Interrupt status and mask
   // -------------------------------------------------------------
   // Write one clears; an event in the same cycle keeps its bit set
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_stat_q <= '0;
         irq_mask_q <= RST_MASK;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((reg_wr_in & sel_istat_w) ?
                        reg_wdata_in[FLAG_N-1:0] : {FLAG_N{1'b0}})) | flag_set_w;
         if (reg_wr_in & sel_imask_w) begin
            irq_mask_q <= reg_wdata_in[FLAG_N-1:0];
         end
      end
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   // Enable bit is left out of the readback on purpose
   assign ctrl_rd_w = {{(DATA_W-MODE_LSB-MODE_W){1'b0}}, mode_q, {MODE_LSB{1'b0}}};
   assign rd_mux_w  = sel_ctrl_w  ? ctrl_rd_w :
                      sel_stat_w  ? status_w :
                      sel_istat_w ? {{(DATA_W-FLAG_N){1'b0}}, irq_stat_q} :
                      sel_imask_w ? {{(DATA_W-FLAG_N){1'b0}}, irq_mask_q} :
                      {DATA_W{1'b0}};

   // Data stand for exactly one cycle after the strobe
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_q    <= '0;
         ext_prev_q <= 1'b0;
      end else begin
         rdata_q    <= reg_rd_in ? rd_mux_w : {DATA_W{1'b0}};
         ext_prev_q <= external_trigger_two_in;
      end
   end

   assign reg_rdata_out = rdata_q;

   // -------------------------------------------------------------
   // Timer
   // -------------------------------------------------------------
   aqms_timer #(
      .CONVERTER_CLOCK_DIV (CONVERTER_CLOCK_DIV)
   ) u_timer (
      .ref_clk_in (ref_clk_in),
      .reset_in   (reset_in),
      .tmr        (tmr_if.timer)
   );

endmodule

// file: tb/aqms_props.sv
// Checker for the queue mode and status block.
// Assumes it is bound onto aqms_top and sees only its ports.
`timescale 1ns/1ps
module aqms_props (
   input wire logic        ref_clk_in,
   input wire logic        reset_in,
   input wire logic [3:0]  reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        q1_active_in,
   input wire logic        conv_done_in,
   input wire logic        q2_run_out,
   input wire logic        q2_trigger_pending_out,
   input wire logic        irq_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // Start request, calm in that cycle and the next, so no suspend or end interferes
   sequence s_sw_go;
      reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[13:8] == 6'h21;
   endsequence
   sequence s_calm;
      (!q1_active_in && !conv_done_in)[*2];
   endsequence
   a_sw_start_run: assert property (s_sw_go ##0 s_calm |=> q2_run_out)
      else $error("no run after software start");
   a_disable_idle: assert property (reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[12:8] == 5'h00 |=> ##1 !q2_run_out)
      else $error("run while disabled");
   a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside read slot");
   a_enable_reads_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h0 |-> !reg_rdata_out[13])
      else $error("enable bit read as one");
   a_unmapped_zero: assert property ($past(reg_rd_in) && ($past(reg_addr_in) & 4'h3) != 4'h0 |-> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_state_no_rsvd: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h4 |-> reg_rdata_out[9:8] != 2'b11)
      else $error("reserved state code");
   a_run_pend_excl: assert property (!(q2_run_out && q2_trigger_pending_out))
      else $error("active and pending together");
   a_mask_off_irq: assert property (reg_wr_in && reg_addr_in == 4'hc && reg_wdata_in[5:0] == 6'h00 |=> !irq_out)
      else $error("interrupt with all masked");
endmodule
bind aqms_top aqms_props u_aqms_props (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .q1_active_in(q1_active_in), .conv_done_in(conv_done_in), .q2_run_out(q2_run_out),
   .q2_trigger_pending_out(q2_trigger_pending_out), .irq_out(irq_out));

// file: tb/testbench.sv
// Self-checking bench for the queue mode and status block.
// Assumes aqms_top with a one-cycle converter clock for short timer runs.
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, trigger_assignment_select = 1'b0;
   logic        done = 1'b0, q2 = 1'b0, last = 1'b0, pse = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wd = 16'h0000;
   logic [15:0] rdv;
   logic        run, pend, irq;
   logic        q1a = 1'b0, q1t = 1'b0, q1e = 1'b0;
   int          num_errors = 0;
   int          n_compared = 0;
   // Queue-one pause input held low; pointer fixed so its copy is visible
   always #12.5 clk = ~clk;
   aqms_top #(.CONVERTER_CLOCK_DIV(1)) u_aqms_top (.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdv),
      .external_trigger_two_in(trigger_assignment_select), .q1_active_in(q1a), .q1_paused_in(1'b0), .q1_ext_mode_in(q1e),
      .q1_trigger_in(q1t), .conv_done_in(done), .conv_queue_two_in(q2), .conv_last_in(last),
      .conv_pause_in(pse), .command_word_pointer_in(6'h2a), .q2_run_out(run),
      .q2_trigger_pending_out(pend), .irq_out(irq));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdv & m, exp);
   endtask
   task automatic conv(input logic q, input logic l, input logic p);
      @(posedge clk);
      done <= 1'b1;
      q2 <= q;
      last <= l;
      pse <= p;
      @(posedge clk);
      done <= 1'b0;
   endtask
   // Bounded wait; a hang shows as a mismatch rather than a stall
   task automatic wait_run(input logic exp, input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         if (run === exp) break;
      end
      chk({15'h0, run}, {15'h0, exp});
   endtask
   task automatic t_reset;
      rdc(4'h4, 16'hffff, 16'h002a);
      rdc(4'h0, 16'hffff, 16'h0000);
      rdc(4'h6, 16'hffff, 16'h0000);
      wrt(4'h4, 16'h03ff);
      rdc(4'h4, 16'h03ff, 16'h002a);
   endtask
   task automatic t_sw_single;
      wrt(4'hc, 16'h003f);
      wrt(4'h0, 16'h2100);
      wait_run(1'b1, 4);
      rdc(4'h0, 16'h2000, 16'h0000);
      conv(1'b1, 1'b0, 1'b1);
      rdc(4'h4, 16'hf3c0, 16'h1040);
      wrt(4'h0, 16'h2100);
      wait_run(1'b1, 4);
      conv(1'b1, 1'b1, 1'b0);
      wait_run(1'b0, 4);
      rdc(4'h4, 16'hf3c0, 16'h3000);
      chk({15'h0, irq}, 16'h0001);
      wrt(4'h4, 16'h0000);
      rdc(4'h4, 16'hf000, 16'h0000);
      wrt(4'h8, 16'h003f);
      #1 chk({15'h0, irq}, 16'h0000);
      conv(1'b0, 1'b1, 1'b0);
      wrt(4'h4, 16'h0000);
      rdc(4'h4, 16'h8000, 16'h8000);
      wrt(4'hc, 16'h0000);
   endtask
   task automatic t_sw_cont;
      wrt(4'h0, 16'h3100);
      wait_run(1'b1, 4);
      conv(1'b1, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk({15'h0, run}, 16'h0001);
      wrt(4'h0, 16'h3100);
      rdc(4'h4, 16'h0400, 16'h0000);
      wrt(4'h0, 16'h0000);
      wait_run(1'b0, 3);
   endtask
   task automatic t_ext;
      wrt(4'h0, 16'h2200);
      @(posedge clk) trigger_assignment_select <= 1'b1;
      wait_run(1'b1, 4);
      @(posedge clk) trigger_assignment_select <= 1'b0;
      @(posedge clk) trigger_assignment_select <= 1'b1;
      conv(1'b1, 1'b1, 1'b0);
      rdc(4'h4, 16'h0400, 16'h0400);
      wrt(4'h0, 16'h2300);
      @(posedge clk) trigger_assignment_select <= 1'b0;
      wait_run(1'b1, 4);
      conv(1'b1, 1'b1, 1'b0);
   endtask
   task automatic t_off;
      wrt(4'h0, 16'h2000);
      repeat (8) @(posedge clk) trigger_assignment_select <= ~trigger_assignment_select;
      #1 chk({15'h0, run}, 16'h0000);
   endtask
   // Queue one busy: queue two waits, runs, then suspends; queue-one overrun
   task automatic t_q1;
      wrt(4'h0, 16'h2200);
      q1a <= 1'b1;
      @(posedge clk) trigger_assignment_select <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({15'h0, pend}, 16'h0001);
      rdc(4'h4, 16'h03c0, 16'h02c0);
      @(posedge clk) q1a <= 1'b0;
      wait_run(1'b1, 4);
      @(posedge clk) q1a <= 1'b1;
      wait_run(1'b0, 4);
      rdc(4'h4, 16'h03c0, 16'h0280);
      @(posedge clk) q1t <= 1'b1;
      @(posedge clk) q1t <= 1'b0;
      rdc(4'h4, 16'h0800, 16'h0000);
      @(posedge clk) begin
         q1a <= 1'b0;
         q1e <= 1'b1;
         q1t <= 1'b1;
      end
      @(posedge clk) q1t <= 1'b0;
      rdc(4'h4, 16'h0800, 16'h0000);
      @(posedge clk) begin
         q1a <= 1'b1;
         q1t <= 1'b1;
      end
      @(posedge clk) q1t <= 1'b0;
      rdc(4'h4, 16'h0800, 16'h0800);
      @(posedge clk) begin
         q1a <= 1'b0;
         q1e <= 1'b0;
      end
      wrt(4'h0, 16'h0000);
   endtask
   task automatic t_timer;
      wrt(4'h0, 16'h2400);
      repeat (120) @(posedge clk);
      #1 chk({15'h0, run}, 16'h0000);
      wait_run(1'b1, 30);
      conv(1'b1, 1'b1, 1'b0);
      wrt(4'h0, 16'h1400);
      wait_run(1'b1, 140);
      conv(1'b1, 1'b1, 1'b0);
      wait_run(1'b0, 3);
      wait_run(1'b1, 140);
      wrt(4'h0, 16'h0000);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Whole run is under a thousand cycles; three thousand means a hang
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_sw_single;
      t_sw_cont;
      t_ext;
      t_off;
      t_q1;
      t_timer;
      wrap_up;
   end
endmodule
